// ==== pkg/fpd_pkg.sv ====
package fpd_pkg;
    // Instruction codes understood by the flash end.
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_RELEASE = 8'hAB;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
    localparam logic [7:0] OP_READ_IDENTITY = 8'h9F;
    localparam logic [7:0] OP_READ_PARAM = 8'h5A;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    // Serial clock counts inside one frame.
    localparam logic [11:0] BITS_OPCODE = 12'h008;
    localparam logic [11:0] BITS_ADDRESS = 12'h020;
    localparam logic [11:0] BITS_PARAM_OUT = 12'h028;
    localparam logic [11:0] BITS_SAT_TOP = 12'hFFF;
    localparam logic [11:0] BITS_SAT_WRAP = 12'hFF8;
    // Security register windows.
    localparam int SR_COUNT = 3;
    localparam int SR_BYTES = 256;
    localparam logic [7:0] SR_HIGH_BYTE = 8'h00;
    localparam logic [7:0] SR1_PAGE = 8'h10;
    localparam logic [7:0] SR2_PAGE = 8'h20;
    localparam logic [7:0] SR3_PAGE = 8'h30;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Times in ns and their cycle counts at the system clock.
    localparam int CLK_PERIOD_NS = 20;
    localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
    localparam int FIRST_RELEASE_TIME_NS = 3000;
    localparam int SECOND_RELEASE_TIME_NS = 1800;
    localparam int SECURITY_ERASE_TIME_NS = 200000;
    localparam int SECURITY_PROG_TIME_NS = 400000;
    localparam int TMR_W = 24;
    // Longest times round down, never below one cycle.
    localparam int PD_ENTRY_CYC = (POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS > 0) ?
        POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS : 1;
    localparam int RES1_CYC = (FIRST_RELEASE_TIME_NS / CLK_PERIOD_NS > 0) ?
        FIRST_RELEASE_TIME_NS / CLK_PERIOD_NS : 1;
    localparam int RES2_CYC = (SECOND_RELEASE_TIME_NS / CLK_PERIOD_NS > 0) ?
        SECOND_RELEASE_TIME_NS / CLK_PERIOD_NS : 1;
    localparam int SE_CYC_DEF = SECURITY_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int PP_CYC_DEF = SECURITY_PROG_TIME_NS / CLK_PERIOD_NS;
    // Host side: the select guard is a least time, so it rounds up.
    localparam int HOST_GUARD_CYC = (FIRST_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SCK_HALF_LAST = 4'h7;
    // Host register map, byte offsets.
    localparam int AVS_ADDR_W = 5;
    localparam logic [4:0] HOST_CMD_OFS = 5'h00;
    localparam logic [4:0] HOST_ADDR_OFS = 5'h04;
    localparam logic [4:0] HOST_WDATA_OFS = 5'h08;
    localparam logic [4:0] HOST_RX_OFS = 5'h0C;
    localparam logic [4:0] HOST_STATUS_OFS = 5'h10;
    // Command register fields.
    localparam int CMD_LEN_LSB = 8;
    localparam int CMD_ADDR_BIT = 16;
endpackage

// ==== pkg/fpd_link_if.sv ====
`timescale 1ns/1ps
interface fpd_link_if;
    logic cs_n;
    logic sclk;
    logic serial_in_pin;
    logic so;
    logic so_oe;
    logic so_line;
    // The output pin is pulled up while the flash leaves it floating.
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input cs_n, input sclk, input serial_in_pin, output so, output so_oe);
    modport host (output cs_n, output sclk, output serial_in_pin, input so_line);
endinterface

// ==== rtl/fpd_flash_dev.sv ====
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// - Sleep needs select rise right after eighth bit.
// - Enter power-down within entry time after select rises.
// - In power-down accept only the release instruction.
// - Reset leaves device in normal operation.
// - Bare release resumes after first release time.
// - Release with dummies streams device ID repeatedly.
// - Host waits second release time after ID release.
// - Release ignored while busy.
// - Manufacturer/device ID alternate, order set by address.
// - Identity read gives manufacturer, type, capacity.
// - Parameter table output starts at fortieth clock.
// - Host zeroes upper address bits for table reads.
// - Three 256-byte security registers at fixed pages.
// - Security erase needs write enable latch set.
// - Erase needs select rise after last address bit.
// - Busy high during erase, status still readable.
// - Erase completion clears write enable latch.
// - Locked security register ignores erase and program.
// - Program needs latch, address, one to 256 bytes.
module fpd_flash_dev #(
    parameter logic [7:0] MANUF_ID = 8'hA5, // Arbitrary value.
    parameter logic [7:0] MEM_TYPE = 8'h5A, // Arbitrary value.
    parameter logic [7:0] CAPACITY = 8'h14, // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'h3C, // Arbitrary value.
    parameter int SE_CYC = fpd_pkg::SE_CYC_DEF,
    parameter int PP_CYC = fpd_pkg::PP_CYC_DEF
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Serial link.
    fpd_link_if.dev link,
    // Lock bits and device state.
    input wire logic [fpd_pkg::SR_COUNT-1:0] otp_lock_bits_i,
    output logic power_down_o,
    output logic busy_o,
    output logic write_enable_latch_flag_o
);
    import fpd_pkg::*;

    typedef enum logic [2:0] {T_IDLE, T_PD_ENTER, T_RELEASE, T_ERASE, T_PROG} fpd_timer_t;

    logic [2:0] sync1_q, sync2_q, sync3_q, pin_q, pin_prev_q;
    logic [11:0] bitc_q;
    logic [31:0] in_sr_q;
    logic [7:0] op_q, pidx_q, tx_q, oidx_q, wp_q;
    logic [23:0] addr_q;
    logic [2:0] ocnt_q;
    logic [SR_BYTES-1:0] pmask_q;
    logic [TMR_W-1:0] tmr_q;
    logic acc_q, got_data_q, so_q, so_oe_q, pd_q, busy_q, wel_q, wp_done_q;
    fpd_timer_t tmr_op_q;
    logic [7:0] pbuf [0:SR_BYTES-1];
    logic [7:0] sec_mem [0:SR_COUNT*SR_BYTES-1];

    // Bit order is {sclk, cs_n, data in}; select idles high.
    wire [2:0] pin_raw = {link.sclk, link.cs_n, link.serial_in_pin};
    wire [2:0] agree = ~(sync2_q ^ sync3_q);

    // Link inputs pass three flops; a level counts once the last two agree.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= 3'h2;
            sync2_q <= 3'h2;
            sync3_q <= 3'h2;
            pin_q <= 3'h2;
            pin_prev_q <= 3'h2;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= (pin_q & ~agree) | (sync3_q & agree);
            pin_prev_q <= pin_q;
        end
    end

    // Edge events seen by the system clock.
    wire sel = ~pin_q[1];
    wire cs_fall = ~pin_q[1] & pin_prev_q[1];
    wire cs_rise = pin_q[1] & ~pin_prev_q[1];
    wire sck_rise = sel & pin_q[2] & ~pin_prev_q[2];
    wire sck_fall = sel & ~pin_q[2] & pin_prev_q[2];
    wire si_v = pin_q[0];
    wire [7:0] byte_in = {in_sr_q[6:0], si_v};

    // Acceptance of the opcode as it completes.
    wire op_ok = pd_q ? (byte_in == OP_RELEASE) :
        (busy_q ? (byte_in == OP_READ_STATUS) : 1'b1);
    wire addr_cap = acc_q & ~busy_q & sck_rise & (bitc_q == BITS_ADDRESS - 12'h001);
    wire data_byte = acc_q & ~busy_q & sck_rise & (op_q == OP_SEC_PROG) &
        (bitc_q >= BITS_ADDRESS) & (bitc_q[2:0] == 3'h7);

    // Security register window decode.
    wire [7:0] page = addr_q[15:8];
    wire reg_ok = (addr_q[23:16] == SR_HIGH_BYTE) &
        ((page == SR1_PAGE) | (page == SR2_PAGE) | (page == SR3_PAGE));
    wire [1:0] sr_idx = addr_q[13:12] - 2'h1;
    wire locked = otp_lock_bits_i[sr_idx];
    wire write_ok = acc_q & wel_q & reg_ok & ~locked;

    // Frame-end actions; release takes any count from eight up, program any whole byte, the rest need an exact count.
    wire end_pd = cs_rise & acc_q & (op_q == OP_DEEP_SLEEP) & (bitc_q == BITS_OPCODE);
    wire end_rel = cs_rise & acc_q & (op_q == OP_RELEASE) & pd_q & (bitc_q >= BITS_OPCODE);
    wire end_wren = cs_rise & acc_q & (op_q == OP_WRITE_ENABLE) & (bitc_q == BITS_OPCODE);
    wire end_wrdi = cs_rise & acc_q & (op_q == OP_WRITE_DISABLE) & (bitc_q == BITS_OPCODE);
    wire end_erase = cs_rise & (op_q == OP_SEC_ERASE) & (bitc_q == BITS_ADDRESS) & write_ok;
    wire end_prog = cs_rise & (op_q == OP_SEC_PROG) & got_data_q & (bitc_q[2:0] == 3'h0) &
        write_ok;

    // Output phase start per instruction.
    wire [11:0] out_start = ((op_q == OP_READ_STATUS) | (op_q == OP_READ_IDENTITY)) ? BITS_OPCODE :
        ((op_q == OP_RELEASE) | (op_q == OP_MFR_DEV_ID)) ? BITS_ADDRESS : BITS_PARAM_OUT;
    wire has_out = (op_q == OP_READ_STATUS) | (op_q == OP_READ_IDENTITY) | (op_q == OP_RELEASE) |
        (op_q == OP_MFR_DEV_ID) | (op_q == OP_READ_PARAM);
    wire out_go = acc_q & has_out & (bitc_q >= out_start);

    // Table content: signature then erased filler; only the low address byte is used.
    function automatic logic [7:0] param_table(input logic [7:0] a);
        logic [7:0] v;
        v = ERASED_BYTE;
        if (a == 8'h00) v = 8'h53;
        if (a == 8'h01) v = 8'h46;
        if (a == 8'h02) v = 8'h44;
        if (a == 8'h03) v = 8'h50;
        return v;
    endfunction

    // Byte selection for the output stream.
    wire [7:0] table_byte = param_table(addr_q[7:0] + oidx_q);
    wire id_swap = oidx_q[0] ^ addr_q[0];
    wire [7:0] ident_byte = (oidx_q == 8'h00) ? MANUF_ID : (oidx_q == 8'h01) ? MEM_TYPE :
        (oidx_q == 8'h02) ? CAPACITY : 8'h00;
    wire [7:0] next_byte = (op_q == OP_READ_STATUS) ? {6'h00, wel_q, busy_q} :
        (op_q == OP_READ_IDENTITY) ? ident_byte :
        (op_q == OP_RELEASE) ? DEV_ID :
        (op_q == OP_MFR_DEV_ID) ? (id_swap ? DEV_ID : MANUF_ID) : table_byte;

    // Input side: counts rising clocks and captures opcode, address and data.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bitc_q <= 12'h000;
            in_sr_q <= 32'h0000_0000;
            op_q <= 8'h00;
            acc_q <= 1'b0;
            addr_q <= 24'h00_0000;
            pidx_q <= 8'h00;
            got_data_q <= 1'b0;
        end else if (cs_fall) begin
            bitc_q <= 12'h000;
            acc_q <= 1'b0;
            if (!busy_q) begin
                got_data_q <= 1'b0;
            end
        end else if (sck_rise) begin
            bitc_q <= (bitc_q == BITS_SAT_TOP) ? BITS_SAT_WRAP : bitc_q + 12'h001;
            in_sr_q <= {in_sr_q[30:0], si_v};
            if (bitc_q == BITS_OPCODE - 12'h001) begin
                op_q <= byte_in;
                acc_q <= op_ok;
            end
            if (addr_cap) begin
                addr_q <= {in_sr_q[22:0], si_v};
                pidx_q <= byte_in;
            end
            if (data_byte) begin
                pidx_q <= pidx_q + 8'h01;
                got_data_q <= 1'b1;
            end
        end
    end

    // Program data lands in a page buffer; extra bytes wrap within the register.
    always_ff @(posedge mclk_i) begin
        if (data_byte) begin
            pbuf[pidx_q] <= byte_in;
        end
    end

    // Marks which buffer bytes were loaded in this frame.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pmask_q <= '0;
        end else if (cs_fall && !busy_q) begin
            pmask_q <= '0;
        end else if (data_byte) begin
            pmask_q[pidx_q] <= 1'b1;
        end
    end

    // Output side: a new bit on each falling clock, MSB first.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so_q <= 1'b1;
            so_oe_q <= 1'b0;
            tx_q <= 8'h00;
            ocnt_q <= 3'h0;
            oidx_q <= 8'h00;
        end else if (cs_fall || cs_rise) begin
            so_oe_q <= 1'b0;
            ocnt_q <= 3'h0;
            oidx_q <= 8'h00;
        end else if (sck_fall && out_go) begin
            so_oe_q <= 1'b1;
            ocnt_q <= ocnt_q + 3'h1;
            if (ocnt_q == 3'h0) begin
                so_q <= next_byte[7];
                tx_q <= {next_byte[6:0], 1'b0};
            end else begin
                so_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (ocnt_q == 3'h7) begin
                oidx_q <= oidx_q + 8'h01;
            end
        end
    end

    // Self-timed operations share one down-counter; only one can run at a time.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tmr_op_q <= T_IDLE;
            tmr_q <= '0;
            pd_q <= 1'b0;
            busy_q <= 1'b0;
            wel_q <= 1'b0;
        end else begin
            if (end_wren) begin
                wel_q <= 1'b1;
            end
            if (end_wrdi) begin
                wel_q <= 1'b0;
            end
            case (tmr_op_q)
                T_IDLE: begin
                    if (end_pd) begin
                        tmr_op_q <= T_PD_ENTER;
                        tmr_q <= TMR_W'(PD_ENTRY_CYC);
                    end else if (end_rel) begin
                        tmr_op_q <= T_RELEASE;
                        tmr_q <= (bitc_q == BITS_OPCODE) ? TMR_W'(RES1_CYC) : TMR_W'(RES2_CYC);
                    end else if (end_erase) begin
                        tmr_op_q <= T_ERASE;
                        tmr_q <= TMR_W'(SE_CYC);
                        busy_q <= 1'b1;
                    end else if (end_prog) begin
                        tmr_op_q <= T_PROG;
                        tmr_q <= TMR_W'(PP_CYC);
                        busy_q <= 1'b1;
                    end
                end
                default: begin
                    if (tmr_q <= TMR_W'(1)) begin
                        tmr_op_q <= T_IDLE;
                        if (tmr_op_q == T_PD_ENTER) begin
                            pd_q <= 1'b1;
                        end
                        if (tmr_op_q == T_RELEASE) begin
                            pd_q <= 1'b0;
                        end
                        if ((tmr_op_q == T_ERASE) || (tmr_op_q == T_PROG)) begin
                            busy_q <= 1'b0;
                            wel_q <= 1'b0;
                        end
                    end else begin
                        tmr_q <= tmr_q - TMR_W'(1);
                    end
                end
            endcase
        end
    end

    // Array update walks all 256 bytes once early in the busy time.
    wire cell_run = ((tmr_op_q == T_ERASE) || (tmr_op_q == T_PROG)) && !wp_done_q;
    wire cell_we = cell_run && ((tmr_op_q == T_ERASE) || pmask_q[wp_q]);
    wire [9:0] cell_a = {sr_idx, wp_q};

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_q <= 8'h00;
            wp_done_q <= 1'b0;
        end else if (tmr_op_q == T_IDLE) begin
            wp_q <= 8'h00;
            wp_done_q <= 1'b0;
        end else if (cell_run) begin
            wp_q <= wp_q + 8'h01;
            wp_done_q <= (wp_q == 8'hFF);
        end
    end

    // Programming only clears bits, so bytes must be erased first to take a value.
    always_ff @(posedge mclk_i) begin
        if (cell_we) begin
            sec_mem[cell_a] <= (tmr_op_q == T_ERASE) ? ERASED_BYTE : (sec_mem[cell_a] & pbuf[wp_q]);
        end
    end

    assign link.so = so_q;
    assign link.so_oe = so_oe_q;
    assign power_down_o = pd_q;
    assign busy_o = busy_q;
    assign write_enable_latch_flag_o = wel_q;
endmodule

// ==== rtl/fpd_flash_host.sv ====
`timescale 1ns/1ps
module fpd_flash_host (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Avalon-MM slave.
    input wire logic [fpd_pkg::AVS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Serial link.
    fpd_link_if.host link
);
    import fpd_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GUARD} fpd_host_state_t;

    fpd_host_state_t st_q;
    logic [23:0] addr_q;
    logic [7:0] wdata_q;
    logic [31:0] rx_q, readdata_q;
    logic [39:0] tx_q;
    logic [10:0] nbits_q, bitn_q;
    logic [3:0] div_q;
    logic [15:0] guard_q;
    logic rd_ack_q, cs_n_q, sclk_q, mosi_q;
    logic so1_q, so2_q, so3_q, so_v_q;

    // Register decode; a command write stalls while a frame is still out.
    wire host_busy = (st_q != H_IDLE);
    wire sel_cmd = (avs_address_i == HOST_CMD_OFS);
    wire sel_addr = (avs_address_i == HOST_ADDR_OFS);
    wire sel_wd = (avs_address_i == HOST_WDATA_OFS);
    wire sel_rx = (avs_address_i == HOST_RX_OFS);
    wire sel_st = (avs_address_i == HOST_STATUS_OFS);
    wire rd_wait = avs_read_i & ~rd_ack_q;
    wire cmd_go = avs_write_i & sel_cmd & ~host_busy;
    assign avs_waitrequest_o = rd_wait | (avs_write_i & sel_cmd & host_busy);
    wire [31:0] rd_mux = sel_addr ? {8'h00, addr_q} : sel_wd ? {24'h00_0000, wdata_q} :
        sel_rx ? rx_q : sel_st ? {31'h0000_0000, host_busy} : 32'h0000_0000;
    wire [7:0] cmd_op = avs_writedata_i[7:0];
    wire [7:0] cmd_len = avs_writedata_i[CMD_LEN_LSB +: 8];
    wire tick = (div_q == SCK_HALF_LAST);
    wire so_agree = (so2_q == so3_q);

    // Register writes and a one-wait read answer.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= 24'h00_0000;
            wdata_q <= 8'h00;
            rd_ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else begin
            rd_ack_q <= rd_wait;
            if (rd_wait) begin
                readdata_q <= rd_mux;
            end
            if (avs_write_i && sel_addr) begin
                addr_q <= avs_writedata_i[23:0];
            end
            if (avs_write_i && sel_wd) begin
                wdata_q <= avs_writedata_i[7:0];
            end
        end
    end

    // Returned data passes three flops; it counts once the last two agree.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so1_q <= 1'b1;
            so2_q <= 1'b1;
            so3_q <= 1'b1;
            so_v_q <= 1'b1;
        end else begin
            so1_q <= link.so_line;
            so2_q <= so1_q;
            so3_q <= so2_q;
            if (so_agree) begin
                so_v_q <= so3_q;
            end
        end
    end

    // Frame engine: mode 0 clock from a divider, sampling late in each high phase.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= H_IDLE;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            tx_q <= 40'h00_0000_0000;
            rx_q <= 32'h0000_0000;
            nbits_q <= 11'h000;
            bitn_q <= 11'h000;
            div_q <= 4'h0;
            guard_q <= 16'h0000;
        end else begin
            div_q <= (tick || st_q == H_IDLE) ? 4'h0 : div_q + 4'h1;
            case (st_q)
                H_IDLE: begin
                    if (cmd_go) begin
                        tx_q <= avs_writedata_i[CMD_ADDR_BIT] ? {cmd_op, addr_q, wdata_q} :
                            {cmd_op, wdata_q, 24'h00_0000};
                        nbits_q <= {(cmd_len == 8'h00) ? 8'h01 : cmd_len, 3'h0};
                        bitn_q <= 11'h000;
                        mosi_q <= cmd_op[7];
                        cs_n_q <= 1'b0;
                        st_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[30:0], so_v_q};
                        tx_q <= {tx_q[38:0], 1'b0};
                        mosi_q <= tx_q[38];
                        bitn_q <= bitn_q + 11'h001;
                        st_q <= (bitn_q + 11'h001 == nbits_q) ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL: begin
                    // Select rises one half clock after the last bit.
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        guard_q <= 16'h0000;
                        st_q <= H_GUARD;
                    end
                end
                H_GUARD: begin
                    // Select stays high long enough for either release time.
                    guard_q <= guard_q + 16'h0001;
                    if (guard_q == 16'(HOST_GUARD_CYC - 1)) begin
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign avs_readdata_o = readdata_q;
    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.serial_in_pin = mosi_q;
endmodule

// ==== testbench/fpd_checker.sv ====
`timescale 1ns/1ps
module fpd_checker (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Link and device state.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in_pin,
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy_o,
    input wire logic power_down_o
);
    // One clock domain, so reset masks every check here.
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    cs_edge_a: assert property ($rose(cs_n) |-> !sclk) else $error("select rose mid bit");
    cs_held_a: assert property ($rose(sclk) |-> !cs_n) else $error("clock outside frame");
    din_stable_a: assert property (sclk |-> $stable(serial_in_pin)) else $error("input moved");
    dout_stable_a: assert property (so_oe && sclk |-> $stable(so)) else $error("output moved");
    out_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe) else $error("output kept");
    guard_high_a: assert property ($rose(cs_n) |-> cs_n[*8]) else $error("select guard short");
    busy_start_a: assert property ($rose(busy_o) |-> cs_n) else $error("busy inside frame");
    // Clock rises in this frame; in sleep only a release frame answers, and only after 32 clocks.
    logic [5:0] rise_cnt_q;
    always_ff @(posedge mclk_i) begin
        rise_cnt_q <= cs_n ? 6'h00 : (rise_cnt_q + {5'h00, $rose(sclk) && (rise_cnt_q != 6'h3F)});
    end
    sleep_quiet_a: assert property (power_down_o && !cs_n && (rise_cnt_q < 6'h20) |-> !so_oe)
        else $error("output in sleep");
    sleep_entry_a: assert property ($rose(power_down_o) |-> cs_n && !busy_o) else $error("bad sleep");
    // Main scenarios that should be reached.
    sleep_c: cover property ($rose(power_down_o));
    busy_c: cover property ($rose(busy_o));
    stream_c: cover property ($rose(so_oe));
endmodule

// ==== testbench/flash_id_powerdown_secreg_cmds_tb.sv ====
`timescale 1ns/1ps
module flash_id_powerdown_secreg_cmds_tb;
    import fpd_pkg::*;
    // Identity bytes are arbitrary values.
    localparam logic [7:0] MID = 8'hC3;
    localparam logic [7:0] MTY = 8'h61;
    localparam logic [7:0] CAP = 8'h17;
    localparam logic [7:0] DID = 8'h2E;
    typedef struct packed {logic [16:0] c; logic [31:0] a; logic [31:0] e;} fpd_row_t;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [2:0] lock = 3'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic wait_o;
    logic pd;
    logic busy;
    logic write_enable_latch_flag;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    // Command word is {send address, bytes on wire, opcode}.
    fpd_row_t rows [6] = '{
        '{{9'h005, OP_READ_IDENTITY}, 32'h0, {MID, MTY, CAP, 8'h00}},
        '{{9'h108, OP_MFR_DEV_ID}, 32'h0, {MID, DID, MID, DID}},
        '{{9'h108, OP_MFR_DEV_ID}, 32'h1, {DID, MID, DID, MID}},
        '{{9'h108, OP_RELEASE}, 32'h0, {4{DID}}},
        '{{9'h109, OP_READ_PARAM}, 32'h0, 32'h53464450},
        '{{9'h108, OP_READ_PARAM}, 32'hFE, 32'hFFFFFF53}};
    fpd_link_if link ();
    fpd_flash_host u_fpd_flash_host (.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .link(link));
    fpd_flash_dev #(.MANUF_ID(MID), .MEM_TYPE(MTY), .CAPACITY(CAP), .DEV_ID(DID), .SE_CYC(3000), .PP_CYC(1000))
        u_fpd_flash_dev (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link), .otp_lock_bits_i(lock),
        .power_down_o(pd), .busy_o(busy), .write_enable_latch_flag_o(write_enable_latch_flag));
    fpd_checker u_fpd_checker (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n(link.cs_n), .sclk(link.sclk),
        .serial_in_pin(link.serial_in_pin), .so(link.so), .so_oe(link.so_oe), .busy_o(busy), .power_down_o(pd));
    always #10 mclk_i = ~mclk_i;
    // A hang ends the run as a failure.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            results();
        end
    end
    // One bus cycle; the request holds until waitrequest is seen low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do @(posedge mclk_i); while (wait_o !== 1'b0);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Run one frame, wait out the guard, then fetch what came back.
    task automatic cmd(input logic [31:0] a, input logic [16:0] c);
        bus(1'b1, HOST_ADDR_OFS, a);
        bus(1'b1, HOST_CMD_OFS, {15'h0, c});
        do bus(1'b0, HOST_STATUS_OFS, 32'h0); while (got[0] !== 1'b0);
        bus(1'b0, HOST_RX_OFS, 32'h0);
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic results();
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        chk(5'h02, {pd, busy, write_enable_latch_flag, link.cs_n, link.sclk});
        bus(1'b1, HOST_WDATA_OFS, 32'h5A);
        foreach (rows[i]) begin
            cmd(rows[i].a, rows[i].c);
            chk(rows[i].e, got);
        end
        // Sleep only counts when select rises right after the opcode.
        cmd(32'h0, {9'h002, OP_DEEP_SLEEP});
        chk(1'b0, pd);
        cmd(32'h0, {9'h001, OP_DEEP_SLEEP});
        repeat (20) @(posedge mclk_i);
        chk(1'b1, pd);
        cmd(32'h0, {9'h005, OP_READ_IDENTITY});
        chk(32'hFFFFFFFF, got);
        cmd(32'h0, {9'h002, OP_READ_STATUS});
        chk(8'hFF, got[7:0]);
        cmd(32'h0, {9'h001, OP_RELEASE});
        repeat (20) @(posedge mclk_i);
        chk(1'b0, pd);
        // Erase refusals: no latch, wrong length, bad page, locked page.
        cmd(32'h001000, {9'h104, OP_SEC_ERASE});
        chk(1'b0, busy);
        cmd(32'h0, {9'h001, OP_WRITE_ENABLE});
        cmd(32'h001000, {9'h105, OP_SEC_ERASE});
        chk(2'h1, {busy, write_enable_latch_flag});
        cmd(32'h004000, {9'h104, OP_SEC_ERASE});
        chk(2'h1, {busy, write_enable_latch_flag});
        lock <= 3'h2;
        cmd(32'h002000, {9'h104, OP_SEC_ERASE});
        chk(2'h1, {busy, write_enable_latch_flag});
        cmd(32'h003000, {9'h104, OP_SEC_ERASE});
        chk(2'h3, {busy, write_enable_latch_flag});
        cmd(32'h0, {9'h002, OP_READ_STATUS});
        chk(8'h03, got[7:0]);
        cmd(32'h0, {9'h108, OP_RELEASE});
        chk(1'b1, busy);
        chk(32'hFFFFFFFF, got);
        do @(posedge mclk_i); while (busy !== 1'b0);
        chk(1'b0, write_enable_latch_flag);
        cmd(32'h0, {9'h001, OP_WRITE_ENABLE});
        cmd(32'h001000, {9'h105, OP_SEC_PROG});
        chk(2'h3, {busy, write_enable_latch_flag});
        do @(posedge mclk_i); while (busy !== 1'b0);
        chk(1'b0, write_enable_latch_flag);
        // ID release from sleep, then sleep again and leave it by a reset.
        cmd(32'h0, {9'h001, OP_DEEP_SLEEP});
        cmd(32'h0, {9'h108, OP_RELEASE});
        chk({4{DID}}, got);
        chk(1'b0, pd);
        cmd(32'h0, {9'h001, OP_DEEP_SLEEP});
        repeat (20) @(posedge mclk_i);
        chk(1'b1, pd);
        resetn_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        chk(1'b0, pd);
        results();
    end
endmodule
